// ==== core/osbpc_top.sv ====
// Pin control of the OBD serial bridge with a Wishbone register port
`timescale 1ns/1ps
`default_nettype none
module osbpc_top #(
  parameter int          MS_CYC     = osbpc_pkg::MS_CYC,
  parameter int          TIMEOUT_MS = osbpc_pkg::TIMEOUT_MS,
  parameter logic [15:0] DIV_SLOW   = osbpc_pkg::DIV_SLOW
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic             wb_ack_out,
  output logic [31:0]      wb_dat_out,
  // Reset pin and straps
  input  wire logic        external_reset_n_in,
  input  wire logic        memory_strap_in,
  input  wire logic        rate_strap_in,
  input  wire logic        line_end_strap_in,
  input  wire logic        params_off_strap_in,
  // Host serial side
  input  wire logic        rts_n_in,
  input  wire logic        serial_receive_in,
  output logic             serial_transmit_out,
  output logic             busy_out,
  // Vehicle bus side
  input  wire logic        variable_pulse_receive_in,
  input  wire logic        iso_receive_n_in,
  input  wire logic        pwm_receive_n_in,
  input  wire logic        can_receive_in,
  output logic             bus_supply_select_out,
  output logic             positive_line_drive_out,
  output logic             negative_line_drive_out,
  output logic             k_line_drive_out,
  output logic             l_line_drive_out,
  output logic             can_transmit_out,
  // Activity indicators, active low
  output logic             serial_receive_indicator_n_out,
  output logic             serial_transmit_indicator_n_out,
  output logic             vehicle_receive_indicator_n_out,
  output logic             vehicle_transmit_indicator_n_out
);

  // Register address match
  function automatic logic osbpc_hit(input logic [7:0] adr, input logic [7:0] off);
    osbpc_hit = (adr == off);
  endfunction : osbpc_hit

  // Input synchronisers
  logic [osbpc_pkg::N_SYNC-1:0] raw;
  logic [osbpc_pkg::N_SYNC-1:0] sync1_q;
  logic [osbpc_pkg::N_SYNC-1:0] sync2_q;

  assign raw = {can_receive_in, pwm_receive_n_in, iso_receive_n_in,
                variable_pulse_receive_in, serial_receive_in, rts_n_in,
                external_reset_n_in, params_off_strap_in, line_end_strap_in,
                rate_strap_in, memory_strap_in};

  // Two flops per input lane
  for (genvar gi = 0; gi < osbpc_pkg::N_SYNC; gi++) begin : g_sync
    always_ff @(posedge clk_in) begin
      sync1_q[gi] <= raw[gi];
      sync2_q[gi] <= sync1_q[gi];
    end
  end

  // Named synchronised levels
  logic rts_n;
  logic srx;
  logic vpw_act;
  logic iso_act;
  logic pwm_act;

  assign rts_n   = sync2_q[osbpc_pkg::S_RTS];
  assign srx     = sync2_q[osbpc_pkg::S_SRX];
  assign vpw_act = sync2_q[osbpc_pkg::S_VPW];
  assign iso_act = !sync2_q[osbpc_pkg::S_ISO];
  assign pwm_act = !sync2_q[osbpc_pkg::S_PWM];

  // Crystal rate tick from fractional accumulator
  logic [7:0] xacc_q;
  logic       xtick_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      xacc_q  <= '0;
      xtick_q <= 1'b0;
    end else if (xacc_q + osbpc_pkg::XTAL_STEP >= osbpc_pkg::XTAL_MOD) begin
      xacc_q  <= xacc_q + osbpc_pkg::XTAL_STEP - osbpc_pkg::XTAL_MOD;
      xtick_q <= 1'b1;
    end else begin
      xacc_q  <= xacc_q + osbpc_pkg::XTAL_STEP;
      xtick_q <= 1'b0;
    end
  end

  // External reset low-time filter
  logic [3:0] xrst_cnt_q;
  logic       xrst_hit;

  assign xrst_hit = (xrst_cnt_q == osbpc_pkg::EXT_RST_TICKS);

  always_ff @(posedge clk_in) begin
    if (srst_in || sync2_q[osbpc_pkg::S_XRST]) begin
      xrst_cnt_q <= '0;
    end else if (xtick_q && !xrst_hit) begin
      xrst_cnt_q <= xrst_cnt_q + 4'h1;
    end
  end

  // Power-on stretch and combined internal reset
  logic [4:0] por_q;
  logic       rst_q;
  logic       rst_d1_q;
  logic       release_p;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      por_q <= '0;
    end else if (por_q != osbpc_pkg::POR_CYC) begin
      por_q <= por_q + 5'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    rst_q    <= srst_in || (por_q != osbpc_pkg::POR_CYC) || xrst_hit;
    rst_d1_q <= rst_q;
  end

  assign release_p = rst_d1_q && !rst_q;

  // Wishbone decode
  logic        ack_q;
  logic        acc;
  logic        wr;
  logic        rd_rxd;
  logic [7:0]  wdat;
  logic [6:0]  cmd;

  assign acc    = wb_cyc_in && wb_stb_in && !ack_q;
  assign wr     = acc && wb_we_in && wb_sel_in[0];
  assign rd_rxd = acc && !wb_we_in && osbpc_hit(wb_adr_in, osbpc_pkg::A_RXD);
  assign wdat   = wb_dat_in[7:0];
  assign cmd    = (wr && osbpc_hit(wb_adr_in, osbpc_pkg::A_CMD)) ? wdat[6:0] : '0;

  // Straps latched once at reset release
  logic fast_q;
  logic pdis_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      fast_q <= 1'b0;
      pdis_q <= 1'b0;
    end else if (release_p) begin
      fast_q <= sync2_q[osbpc_pkg::S_RATE];
      pdis_q <= !sync2_q[osbpc_pkg::S_POFF];
    end
  end

  // Memory option: strap default, commands override
  logic mem_en_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      mem_en_q <= 1'b0;
    end else if (release_p) begin
      mem_en_q <= sync2_q[osbpc_pkg::S_MEM];
    end else if (cmd[osbpc_pkg::K_MON]) begin
      mem_en_q <= 1'b1;
    end else if (cmd[osbpc_pkg::K_MOFF]) begin
      mem_en_q <= 1'b0;
    end
  end

  // Line-end mode: strap default, commands override
  logic lf_en_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      lf_en_q <= 1'b0;
    end else if (release_p) begin
      lf_en_q <= sync2_q[osbpc_pkg::S_LE];
    end else if (cmd[osbpc_pkg::K_LON]) begin
      lf_en_q <= 1'b1;
    end else if (cmd[osbpc_pkg::K_LOFF]) begin
      lf_en_q <= 1'b0;
    end
  end

  // Programmed rate divisor and selected bit period
  logic [15:0] rate_q;
  logic [15:0] div_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      rate_q <= osbpc_pkg::DIV_FAST;
    end else if (acc && wb_we_in && osbpc_hit(wb_adr_in, osbpc_pkg::A_RATE)) begin
      if (wb_sel_in[0]) rate_q[7:0]  <= wb_dat_in[7:0];
      if (wb_sel_in[1]) rate_q[15:8] <= wb_dat_in[15:8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!fast_q) begin
      div_q <= DIV_SLOW;
    end else if (pdis_q) begin
      div_q <= osbpc_pkg::DIV_FAST;
    end else begin
      div_q <= rate_q;
    end
  end

  // Vehicle drive control; RTS low clears the positive, negative, K and L drive bits, not supply select or CAN
  logic [5:0] ctrl_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      ctrl_q <= osbpc_pkg::CTRL_RST;
    end else begin
      if (wr && osbpc_hit(wb_adr_in, osbpc_pkg::A_CTRL)) ctrl_q <= wdat[5:0];
      if (!rts_n) ctrl_q[osbpc_pkg::C_LD:osbpc_pkg::C_POS] <= '0;
    end
  end

  // Receiver
  osbpc_pkg::osbpc_ser_e rx_st_q;
  logic [15:0] rcnt_q;
  logic [2:0]  rbit_q;
  logic [7:0]  rsh_q;
  logic        rdone_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      rx_st_q <= osbpc_pkg::SER_IDLE;
      rcnt_q  <= '0;
      rbit_q  <= '0;
      rsh_q   <= '0;
      rdone_q <= 1'b0;
    end else begin
      rdone_q <= 1'b0;
      if (rcnt_q != '0) rcnt_q <= rcnt_q - 16'h0001;
      case (rx_st_q)
        osbpc_pkg::SER_IDLE: begin
          if (!srx) begin
            rx_st_q <= osbpc_pkg::SER_START;
            rcnt_q  <= {1'b0, div_q[15:1]};
          end
        end
        osbpc_pkg::SER_START: begin
          if (rcnt_q == '0) begin
            rx_st_q <= srx ? osbpc_pkg::SER_IDLE : osbpc_pkg::SER_DATA;
            rcnt_q  <= div_q - 16'h0001;
            rbit_q  <= '0;
          end
        end
        osbpc_pkg::SER_DATA: begin
          if (rcnt_q == '0) begin
            rsh_q  <= {srx, rsh_q[7:1]};
            rbit_q <= rbit_q + 3'h1;
            rcnt_q <= div_q - 16'h0001;
            if (rbit_q == osbpc_pkg::LAST_BIT) rx_st_q <= osbpc_pkg::SER_STOP;
          end
        end
        osbpc_pkg::SER_STOP: begin
          if (rcnt_q == '0) begin
            rdone_q <= srx;
            rx_st_q <= osbpc_pkg::SER_IDLE;
          end
        end
        default: rx_st_q <= osbpc_pkg::SER_IDLE;
      endcase
    end
  end

  // Received character holding register; a new character wins over a read
  logic [7:0] rxd_q;
  logic       rxv_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      rxd_q <= '0;
      rxv_q <= 1'b0;
    end else if (rdone_q) begin
      rxd_q <= rsh_q;
      rxv_q <= 1'b1;
    end else if (rd_rxd) begin
      rxv_q <= 1'b0;
    end
  end

  // Line tracking and idle timeout
  logic        linep_q;
  logic [16:0] mscnt_q;
  logic [14:0] tocnt_q;
  logic        ms_tick;
  logic        to_hit;
  logic        got_cr;

  assign got_cr  = rdone_q && (rsh_q == osbpc_pkg::CH_CR);
  assign ms_tick = (mscnt_q == 17'(MS_CYC - 1));
  // A character landing on the last tick keeps the line alive
  assign to_hit  = linep_q && ms_tick && !rdone_q && (tocnt_q == 15'(TIMEOUT_MS - 1));

  always_ff @(posedge clk_in) begin
    if (rst_q || rdone_q || !linep_q || ms_tick) begin
      mscnt_q <= '0;
    end else begin
      mscnt_q <= mscnt_q + 17'h0_0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_q || rdone_q || !linep_q) begin
      tocnt_q <= '0;
    end else if (ms_tick) begin
      tocnt_q <= tocnt_q + 15'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_q || got_cr || to_hit || !rts_n) begin
      linep_q <= 1'b0;
    end else if (rdone_q) begin
      linep_q <= 1'b1;
    end
  end

  // Busy: set by completed line, cleared by done command or RTS
  logic busy_q;

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      busy_q <= 1'b0;
    end else if (got_cr) begin
      busy_q <= 1'b1;
    end else if (cmd[osbpc_pkg::K_DONE] || !rts_n) begin
      busy_q <= 1'b0;
    end
  end

  // Transmit pending sources
  osbpc_pkg::osbpc_ser_e tx_st_q;
  logic [7:0] txd_q;
  logic       txp_q;
  logic       qmp_q;
  logic       crp_q;
  logic       lfp_q;
  logic       take;
  logic       take_qm;
  logic       take_sw;
  logic       take_cr;
  logic       take_lf;

  assign take    = (tx_st_q == osbpc_pkg::SER_IDLE);
  assign take_qm = take && qmp_q;
  assign take_sw = take && !qmp_q && txp_q;
  assign take_cr = take && !qmp_q && !txp_q && crp_q;
  assign take_lf = take && !qmp_q && !txp_q && !crp_q && lfp_q;

  // Software byte
  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      txd_q <= '0;
      txp_q <= 1'b0;
    end else if (take_sw) begin
      txp_q <= 1'b0;
    end else if (wr && !txp_q && osbpc_hit(wb_adr_in, osbpc_pkg::A_TXD)) begin
      txd_q <= wdat;
      txp_q <= 1'b1;
    end
  end

  // Timeout reply and line end sequence
  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      qmp_q <= 1'b0;
      crp_q <= 1'b0;
      lfp_q <= 1'b0;
    end else begin
      if (to_hit) qmp_q <= 1'b1;
      else if (take_qm) qmp_q <= 1'b0;
      if (cmd[osbpc_pkg::K_EOL]) begin
        crp_q <= 1'b1;
        lfp_q <= lf_en_q;
      end else begin
        if (take_cr) crp_q <= 1'b0;
        if (take_lf) lfp_q <= 1'b0;
      end
    end
  end

  // Transmitter
  logic [15:0] tcnt_q;
  logic [2:0]  tbit_q;
  logic [7:0]  tsh_q;
  logic        ttick;

  assign ttick = (tcnt_q == '0);

  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      tx_st_q <= osbpc_pkg::SER_IDLE;
      tcnt_q  <= '0;
      tbit_q  <= '0;
      tsh_q   <= '0;
    end else begin
      tcnt_q <= ttick ? div_q - 16'h0001 : tcnt_q - 16'h0001;
      case (tx_st_q)
        osbpc_pkg::SER_IDLE: begin
          tcnt_q <= div_q - 16'h0001;
          tbit_q <= '0;
          if (take_qm) tsh_q <= osbpc_pkg::CH_QM;
          else if (take_sw) tsh_q <= txd_q;
          else if (take_cr) tsh_q <= osbpc_pkg::CH_CR;
          else if (take_lf) tsh_q <= osbpc_pkg::CH_LF;
          if (qmp_q || txp_q || crp_q || lfp_q) tx_st_q <= osbpc_pkg::SER_START;
        end
        osbpc_pkg::SER_START: begin
          if (ttick) tx_st_q <= osbpc_pkg::SER_DATA;
        end
        osbpc_pkg::SER_DATA: begin
          if (ttick) begin
            tsh_q  <= {1'b0, tsh_q[7:1]};
            tbit_q <= tbit_q + 3'h1;
            if (tbit_q == osbpc_pkg::LAST_BIT) tx_st_q <= osbpc_pkg::SER_STOP;
          end
        end
        osbpc_pkg::SER_STOP: begin
          if (ttick) tx_st_q <= osbpc_pkg::SER_IDLE;
        end
        default: tx_st_q <= osbpc_pkg::SER_IDLE;
      endcase
    end
  end

  // Serial line level and busy pin
  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      serial_transmit_out <= 1'b1;
      busy_out            <= 1'b0;
    end else begin
      serial_transmit_out <= (tx_st_q == osbpc_pkg::SER_START) ? 1'b0 :
                             (tx_st_q == osbpc_pkg::SER_DATA) ? tsh_q[0] : 1'b1;
      busy_out            <= busy_q;
    end
  end

  // Vehicle bus pins
  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      bus_supply_select_out   <= 1'b0;
      positive_line_drive_out <= 1'b0;
      negative_line_drive_out <= 1'b0;
      k_line_drive_out        <= 1'b0;
      l_line_drive_out        <= 1'b0;
      can_transmit_out        <= 1'b1;
    end else begin
      bus_supply_select_out   <= ctrl_q[osbpc_pkg::C_VPW];
      positive_line_drive_out <= ctrl_q[osbpc_pkg::C_POS];
      negative_line_drive_out <= ctrl_q[osbpc_pkg::C_NEG] && !ctrl_q[osbpc_pkg::C_VPW];
      k_line_drive_out        <= ctrl_q[osbpc_pkg::C_KD];
      l_line_drive_out        <= ctrl_q[osbpc_pkg::C_LD];
      can_transmit_out        <= ctrl_q[osbpc_pkg::C_CAN];
    end
  end

  // Activity indicators, low while active
  always_ff @(posedge clk_in) begin
    if (rst_q) begin
      serial_receive_indicator_n_out   <= 1'b1;
      serial_transmit_indicator_n_out  <= 1'b1;
      vehicle_receive_indicator_n_out  <= 1'b1;
      vehicle_transmit_indicator_n_out <= 1'b1;
    end else begin
      serial_receive_indicator_n_out   <= (rx_st_q == osbpc_pkg::SER_IDLE);
      serial_transmit_indicator_n_out  <= (tx_st_q == osbpc_pkg::SER_IDLE);
      vehicle_receive_indicator_n_out  <= !(vpw_act || iso_act || pwm_act ||
                                            !sync2_q[osbpc_pkg::S_CAN]);
      vehicle_transmit_indicator_n_out <= !((|ctrl_q[osbpc_pkg::C_LD:osbpc_pkg::C_POS]) ||
                                            !ctrl_q[osbpc_pkg::C_CAN]);
    end
  end

  // Status word
  logic [31:0] stat;

  assign stat = {20'h0_0000, !sync2_q[osbpc_pkg::S_CAN], pwm_act, iso_act, vpw_act,
                 !take, linep_q, !rts_n, busy_q, pdis_q, fast_q, lf_en_q, mem_en_q};

  // Bus answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_q      <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      ack_q <= acc;
      if (acc && !wb_we_in) begin
        case (wb_adr_in)
          osbpc_pkg::A_CTRL: wb_dat_out <= {26'h000_0000, ctrl_q};
          osbpc_pkg::A_RXD:  wb_dat_out <= {23'h00_0000, rxv_q, rxd_q};
          osbpc_pkg::A_STAT: wb_dat_out <= stat;
          osbpc_pkg::A_RATE: wb_dat_out <= {16'h0000, rate_q};
          default:           wb_dat_out <= '0;
        endcase
      end
    end
  end

  assign wb_ack_out = ack_q;

endmodule : osbpc_top
`default_nettype wire

// ==== core/osbpc_pkg.sv ====
// Constants and types for the OBD serial bridge pin control block
`default_nettype none
package osbpc_pkg;
  // Clock and crystal reference
  localparam int         CLK_HZ    = 125_000_000;
  localparam int         XTAL_HZ   = 4_000_000;
  localparam logic [7:0] XTAL_STEP = 8'(XTAL_HZ / 1_000_000);
  localparam logic [7:0] XTAL_MOD  = 8'(CLK_HZ / 1_000_000);
  // External reset filter, longer than 2 us in crystal ticks
  localparam int         EXT_RST_NS    = 2000;
  localparam logic [3:0] EXT_RST_TICKS = 4'(EXT_RST_NS * (XTAL_HZ / 1_000_000) / 1000 + 1);
  // Internal power-on reset stretch in clock cycles
  localparam logic [4:0] POR_CYC = 5'h10;
  // Serial rates and bit dividers
  localparam int          BAUD_FAST = 38400;
  localparam int          BAUD_SLOW = 9600;
  localparam logic [15:0] DIV_FAST  = 16'(CLK_HZ / BAUD_FAST);
  localparam logic [15:0] DIV_SLOW  = 16'(CLK_HZ / BAUD_SLOW);
  // Incomplete line timeout
  localparam int TIMEOUT_S  = 20;
  localparam int MS_PER_S   = 1000;
  localparam int MS_CYC     = CLK_HZ / MS_PER_S;
  localparam int TIMEOUT_MS = TIMEOUT_S * MS_PER_S;
  // Characters
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_QM    = 8'h3F;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD  = 8'h04;
  localparam logic [7:0] A_TXD  = 8'h08;
  localparam logic [7:0] A_RXD  = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RATE = 8'h14;
  // Control register fields and reset value
  localparam int C_VPW = 0, C_POS = 1, C_NEG = 2, C_KD = 3, C_LD = 4, C_CAN = 5;
  localparam logic [5:0] CTRL_RST = 6'h20;
  // Command register pulse fields and receive data valid bit
  localparam int K_MON = 0, K_MOFF = 1, K_LON = 2, K_LOFF = 3, K_EOL = 4, K_DONE = 5;
  localparam int RX_VALID = 8;
  // Synchroniser lanes
  localparam int N_SYNC = 11;
  localparam int S_MEM = 0, S_RATE = 1, S_LE = 2, S_POFF = 3, S_XRST = 4, S_RTS = 5;
  localparam int S_SRX = 6, S_VPW = 7, S_ISO = 8, S_PWM = 9, S_CAN = 10;
  // Serial engine states
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b10,
    SER_STOP  = 2'b11
  } osbpc_ser_e;
endpackage : osbpc_pkg
`default_nettype wire

// ==== sim/osbpc_sva.sv ====
// Port checker for the OBD bridge pin control block
`timescale 1ns/1ps
`default_nettype none
module osbpc_sva (
  // Clock, reset and register bus
  input wire logic        clk_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in, wb_dat_out,
  // Pins
  input wire logic        external_reset_n_in, rts_n_in, serial_transmit_out, busy_out,
  input wire logic        bus_supply_select_out, positive_line_drive_out,
  input wire logic        negative_line_drive_out, k_line_drive_out, l_line_drive_out,
  input wire logic        can_transmit_out
);
  localparam int EXT_LONG = 300;
  logic [8:0] low_q;
  logic [5:0] wd_q;
  logic       req, wr_ctrl, drv;
  // Request and drive summaries
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_ctrl = req && wb_we_in && wb_adr_in == osbpc_pkg::A_CTRL && wb_sel_in[0];
  assign drv = positive_line_drive_out | negative_line_drive_out | k_line_drive_out
             | l_line_drive_out;
  // Length of the low stretch on the reset pin
  always_ff @(posedge clk_in) low_q <= external_reset_n_in ? 9'h000 : low_q + 9'(low_q != 9'h1FF);
  // Last data written to the control register
  always_ff @(posedge clk_in) if (wr_ctrl) wd_q <= wb_dat_in[5:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_ack_answer: assert property (req |=> wb_ack_out) else $error("no ack");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without request");
  a_unmapped_zero: assert property (req && !wb_we_in && wb_adr_in == 8'h40 |=> wb_dat_out == 0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(srst_in) |-> (serial_transmit_out && !busy_out) [*8])
    else $error("serial pins not idle after reset");
  a_reset_drives: assert property ($fell(srst_in) |-> !drv && can_transmit_out)
    else $error("bus drives active after reset");
  a_neg_pwm_only: assert property (negative_line_drive_out |-> !bus_supply_select_out)
    else $error("negative drive with high supply");
  a_supply_follow: assert property (wr_ctrl |-> ##[1:3] bus_supply_select_out == wd_q[0])
    else $error("supply select not updated");
  a_line_follow: assert property (wr_ctrl |-> ##[1:3] positive_line_drive_out == wd_q[1]
    && k_line_drive_out == wd_q[3] && l_line_drive_out == wd_q[4]) else $error("drive mismatch");
  a_rts_drop: assert property (!rts_n_in [*5] |-> !drv) else $error("drives kept in attention");
  a_ext_reset: assert property (low_q >= EXT_LONG |-> !busy_out && !drv && serial_transmit_out)
    else $error("reset pin ignored");
  c_ctrl: cover property (wr_ctrl);
  c_rts: cover property (!rts_n_in [*5]);
  c_ext: cover property (low_q >= EXT_LONG);
endmodule : osbpc_sva
bind osbpc_top osbpc_sva i_osbpc_sva (.*);
`default_nettype wire

// ==== sim/osbpc_host.sv ====
// Host serial terminal model: receive line and attention request
`timescale 1ns/1ps
`default_nettype none
module osbpc_host (
  // Clock and busy sense
  input  wire logic clk_in,
  input  wire logic busy_in,
  // Lines toward the bridge
  output logic      rx_out,
  output logic      rts_n_out
);
  // Idle line high, no attention
  initial begin
    rx_out = 1'b1;
    rts_n_out = 1'b1;
  end
  // One 8N1 character, LSB first
  task automatic send(input logic [7:0] b, input int div);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_out <= f[i];
      repeat (div) @(posedge clk_in);
    end
  endtask : send
  // Hold attention until not busy, then release
  task automatic attend(output logic ok);
    int n;
    rts_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (n = 0; n < 100 && busy_in !== 1'b0; n++) @(posedge clk_in);
    ok = busy_in === 1'b0;
    rts_n_out <= 1'b1;
  endtask : attend
endmodule : osbpc_host
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the OBD bridge pin control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, ok;
  logic [7:0] wb_adr_in, ch;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic external_reset_n_in, memory_strap_in, rate_strap_in, line_end_strap_in;
  logic params_off_strap_in, rts_n_in, serial_receive_in, serial_transmit_out, busy_out;
  logic variable_pulse_receive_in, iso_receive_n_in, pwm_receive_n_in, can_receive_in;
  logic bus_supply_select_out, positive_line_drive_out, negative_line_drive_out;
  logic k_line_drive_out, l_line_drive_out, can_transmit_out;
  logic serial_receive_indicator_n_out, serial_transmit_indicator_n_out;
  logic vehicle_receive_indicator_n_out, vehicle_transmit_indicator_n_out;
  logic [5:0] cv [2] = '{6'h1F, 6'h24};
  logic [5:0] ex [2] = '{6'h1B, 6'h24};
  int bad_count, n_tests;
  osbpc_top #(.MS_CYC(10), .TIMEOUT_MS(3), .DIV_SLOW(16'h0010)) i_osbpc_top (.*);
  osbpc_host i_osbpc_host (.clk_in(clk_in), .busy_in(busy_out), .rx_out(serial_receive_in),
    .rts_n_out(rts_n_in));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    for (n = 0; n < 50 && wb_ack_out !== 1'b1; n++) @(posedge clk_in);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    chk(n < 50, 1);
    if (n >= 50) print_verdict();
    @(posedge clk_in);
  endtask : wb
  // One character off the transmit pin, 16 cycles a bit
  task automatic get(output logic [7:0] c);
    int n;
    for (n = 0; n < 3000 && serial_transmit_out !== 1'b0; n++) @(posedge clk_in);
    chk(n < 3000, 1);
    if (n >= 3000) print_verdict();
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_in);
      c[i] = serial_transmit_out;
    end
    repeat (16) @(posedge clk_in);
    chk(serial_transmit_out, 1'b1);
  endtask : get
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    int n;
    {srst_in, external_reset_n_in, memory_strap_in, rate_strap_in} = 4'hF;
    {line_end_strap_in, params_off_strap_in, wb_cyc_in, wb_stb_in, wb_we_in} = 5'h18;
    {variable_pulse_receive_in, iso_receive_n_in, pwm_receive_n_in, can_receive_in} = 4'h7;
    {wb_adr_in, wb_sel_in, wb_dat_in} = 44'h00F_0000_0000;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    chk({serial_transmit_out, busy_out, serial_receive_indicator_n_out,
      serial_transmit_indicator_n_out, vehicle_receive_indicator_n_out,
      vehicle_transmit_indicator_n_out}, 6'h2F);
    wb(0, osbpc_pkg::A_STAT, 0);
    chk(rd[11:0], 12'h007);
    wb(0, osbpc_pkg::A_RATE, 0);
    chk(rd[15:0], 16'h0CB7);
    wb(1, osbpc_pkg::A_RATE, 32'h0000_0010);
    {variable_pulse_receive_in, iso_receive_n_in, pwm_receive_n_in, can_receive_in} <= 4'h8;
    repeat (4) @(posedge clk_in);
    chk(vehicle_receive_indicator_n_out, 1'b0);
    wb(0, osbpc_pkg::A_STAT, 0);
    chk(rd[11:8], 4'hF);
    {variable_pulse_receive_in, iso_receive_n_in, pwm_receive_n_in, can_receive_in} <= 4'h7;
    for (int i = 0; i < 3; i++) begin
      wb(1, osbpc_pkg::A_CMD, i[0] ? 32'h0000_0005 : 32'h0000_000A);
      wb(0, osbpc_pkg::A_STAT, 0);
      chk(rd[1:0], i[0] ? 2'b11 : 2'b00);
    end
    wb(1, osbpc_pkg::A_CMD, 32'h0000_0004);
    wb(1, osbpc_pkg::A_CMD, 32'h0000_0010);
    get(ch);
    chk(ch, 8'h0D);
    get(ch);
    chk(ch, 8'h0A);
    wb(1, osbpc_pkg::A_TXD, 32'h0000_0055);
    get(ch);
    chk(ch, 8'h55);
    foreach (cv[i]) begin
      wb(1, osbpc_pkg::A_CTRL, {26'h0, cv[i]});
      repeat (3) @(posedge clk_in);
      chk({can_transmit_out, l_line_drive_out, k_line_drive_out, negative_line_drive_out,
        positive_line_drive_out, bus_supply_select_out}, ex[i]);
    end
    wb(0, 8'h40, 0);
    chk(rd, 32'h0000_0000);
    wb(1, osbpc_pkg::A_CTRL, 32'h0000_001A);
    fork
      i_osbpc_host.send(8'h41, 16);
      get(ch);
    join
    chk(ch, 8'h3F);
    i_osbpc_host.send(8'h0D, 16);
    for (n = 0; n < 100 && busy_out !== 1'b1; n++) @(posedge clk_in);
    chk(busy_out, 1'b1);
    if (n >= 100) print_verdict();
    i_osbpc_host.attend(ok);
    chk({ok, k_line_drive_out, positive_line_drive_out}, 3'b100);
    if (!ok) print_verdict();
    wb(0, osbpc_pkg::A_RXD, 0);
    chk(rd[8:0], 9'h10D);
    i_osbpc_host.send(8'h0D, 16);
    chk(busy_out, 1'b1);
    wb(1, osbpc_pkg::A_CMD, 32'h0000_0020);
    chk(busy_out, 1'b0);
    {external_reset_n_in, params_off_strap_in, rate_strap_in} <= 3'b000;
    repeat (300) @(posedge clk_in);
    external_reset_n_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    wb(0, osbpc_pkg::A_STAT, 0);
    chk(rd[3:0], 4'hB);
    wb(1, osbpc_pkg::A_TXD, 32'h0000_003C);
    get(ch);
    chk(ch, 8'h3C);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
